// ===== ebs_consts.svh
// Offsets, field positions, reset values and codes of the bus signal select block
`ifndef EBS_CONSTS_SVH
`define EBS_CONSTS_SVH
`define EBS_WAIT_CTRL_INDEX 12'h0a7
`define EBS_CFG_INDEX     12'h0a8
`define EBS_STAT_INDEX    12'h0a9
`define EBS_WAIT_EN_BIT   0
`define EBS_WCLK_EN_BIT   1
`define EBS_WAIT_CTRL_RESET 2'h0
`define EBS_SEL_256K      2'h0
`define EBS_SEL_128K      2'h1
`define EBS_SEL_64K       2'h2
`define EBS_SEL_COMPAT    2'h3
`define EBS_SPLIT_ADDR    24'h800000
`define EBS_LEGACY_PAGE   8'h01
`define EBS_ADDR_A16      16
`define EBS_ADDR_A17      17
`endif

// ===== ebs_pkg.sv
// Types shared by the bus signal select block
package ebs_pkg;
  typedef enum logic [2:0] {
    EBS_IDLE = 3'h1,
    EBS_ADDR = 3'h2,
    EBS_DATA = 3'h4
  } ebs_state_e;
  typedef logic [1:0] ebs_sel_t;
endpackage

// ===== ebs_wclk_gen.sv
// Wait clock generator: half-rate square wave of the oscillator clock
`timescale 1ns/10ps
`default_nettype none
module ebs_wclk_gen (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  output var  logic wclk
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wclk <= 1'b0;
    end else if (enable) begin
      wclk <= ~wclk; // [R9]
    end else begin
      wclk <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== ebs_top.sv
// External bus signal select: address/strobe routing, wait control and APB registers
//
// Notes on behaviour
// [R1] Code 00 puts A17 on port1_bit7 and A16 on port3_bit7; 01 only A16.
// [R2] Codes 00, 01, 10 assert program read and write strobes for all addresses.
// [R3] Code 10 leaves port3_bit7 a plain port pin, no A16 or A17.
// [R4] Code 11: data read strobe up to 7F:FFFFH, program read from 80:0000H.
// [R5] Code 11: write strobe only for writes into the legacy data region.
// [R6] Wait request input works only once realtime_wait_enable is written 1.
// [R7] External memory signals readiness by driving the wait request input.
// [R8] Wait clock appears on port1_bit7 only with realtime_wait_clock_enable set.
// [R9] Wait clock is a continuous square wave at half the oscillator rate.
// [R10] Page mode: port 0 holds A7:0, port 2 carries A15:8 then data.
// [R11] All timing comes from the single oscillator clock input.
// [R12] Selection field is a configuration strap, caught once, not software writable.
// [R13] Enabled wait request held low stretches the bus cycle until it rises.
// [R14] Both wait control enable bits are 0 after reset.
`timescale 1ns/10ps
`default_nettype none
`include "ebs_consts.svh"
module ebs_top #(
  parameter int ADDR_W = 24
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [1:0]        memory_signal_select_strap,
  input  wire logic              page_mode_strap,
  input  wire logic              bus_req,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic              bus_write,
  input  wire logic [7:0]        bus_wdata,
  output var  logic [7:0]        bus_rdata,
  output var  logic              bus_done,
  output var  logic              bus_busy,
  input  wire logic              wait_request_n,
  input  wire logic              port1_bit7_gpio,
  input  wire logic              port3_bit7_gpio,
  input  wire logic [7:0]        port0_in,
  input  wire logic [7:0]        port2_in,
  output var  logic              port1_bit7_out,
  output var  logic              port3_bit7_out,
  output var  logic              program_read_strobe_n,
  output var  logic              write_strobe_n,
  output var  logic [7:0]        port0_out,
  output var  logic              port0_oe,
  output var  logic [7:0]        port2_out,
  output var  logic              port2_oe
);
  ebs_pkg::ebs_state_e state;
  ebs_pkg::ebs_state_e next_state;
  ebs_pkg::ebs_sel_t   mss;
  logic                page_mode;
  logic                cfg_valid;
  logic [1:0]          wait_control;
  logic [ADDR_W-1:0]   lat_addr;
  logic                lat_write;
  logic [7:0]          lat_wdata;
  logic                wclk;
  logic                stalled;
  logic                apb_done;
  logic                data_end;

  function automatic logic is_idx(input logic [11:0] a, input logic [11:0] idx);
    return a == {idx[9:0], 2'b00};
  endfunction

  function automatic logic prog_hit(input ebs_pkg::ebs_sel_t s, input logic [ADDR_W-1:0] a);
    if (s == `EBS_SEL_COMPAT) begin
      return a >= ADDR_W'(`EBS_SPLIT_ADDR); // [R4]
    end
    return 1'b1; // [R2]
  endfunction

  function automatic logic wr_hit(input ebs_pkg::ebs_sel_t s, input logic [ADDR_W-1:0] a);
    if (s == `EBS_SEL_COMPAT) begin
      return a[ADDR_W-1:16] == (ADDR_W-16)'(`EBS_LEGACY_PAGE); // [R5]
    end
    return 1'b1; // [R2]
  endfunction

  // Straps are sampled once, on the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_valid <= 1'b0;
      mss       <= `EBS_SEL_256K;
      page_mode <= 1'b0;
    end else if (!cfg_valid) begin
      cfg_valid <= 1'b1;
      mss       <= memory_signal_select_strap; // [R12]
      page_mode <= page_mode_strap;
    end
  end

  assign apb_done = psel && penable && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_control <= `EBS_WAIT_CTRL_RESET; // [R14]
    end else if (apb_done && pwrite && is_idx(paddr, `EBS_WAIT_CTRL_INDEX)) begin
      wait_control <= pwdata[1:0]; // [R6] [R8]
    end
  end

  // APB slave: answer in the first cycle of the access phase, no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable) begin
        if (is_idx(paddr, `EBS_WAIT_CTRL_INDEX)) begin
          prdata <= {30'h0, wait_control};
        end else if (is_idx(paddr, `EBS_CFG_INDEX)) begin
          prdata <= {29'h0, page_mode, mss};
        end else if (is_idx(paddr, `EBS_STAT_INDEX)) begin
          prdata <= {28'h0, stalled, state};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  assign stalled = (state == ebs_pkg::EBS_DATA) && wait_control[`EBS_WAIT_EN_BIT]
                   && !wait_request_n;

  always_comb begin
    next_state = state;
    case (state)
      ebs_pkg::EBS_IDLE: begin
        if (bus_req && cfg_valid) begin
          next_state = ebs_pkg::EBS_ADDR;
        end
      end
      ebs_pkg::EBS_ADDR: begin
        next_state = ebs_pkg::EBS_DATA;
      end
      ebs_pkg::EBS_DATA: begin
        if (!stalled) begin // [R13] [R7]
          next_state = ebs_pkg::EBS_IDLE;
        end
      end
      default: begin
        next_state = ebs_pkg::EBS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ebs_pkg::EBS_IDLE;
    end else begin
      state <= next_state; // [R11]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_addr  <= '0;
      lat_write <= 1'b0;
      lat_wdata <= 8'h0;
    end else if (state == ebs_pkg::EBS_IDLE && bus_req && cfg_valid) begin
      lat_addr  <= bus_addr;
      lat_write <= bus_write;
      lat_wdata <= bus_wdata;
    end
  end

  // Read byte is taken one edge after the data phase: pins lag state by a cycle,
  // so at the data phase edge they still show our own address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_end  <= 1'b0;
      bus_done  <= 1'b0;
      bus_busy  <= 1'b0;
      bus_rdata <= 8'h0;
    end else begin
      data_end <= (state == ebs_pkg::EBS_DATA) && !stalled;
      bus_done <= data_end;
      bus_busy <= state != ebs_pkg::EBS_IDLE;
      if (data_end && !lat_write) begin
        bus_rdata <= page_mode ? port2_in : port0_in;
      end
    end
  end

  ebs_wclk_gen u_wclk (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (wait_control[`EBS_WCLK_EN_BIT]),
    .wclk    (wclk)
  );

  // Multiplexed pins and strobes, registered copies of the current phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_bit7_out        <= 1'b1;
      port3_bit7_out        <= 1'b1;
      program_read_strobe_n <= 1'b1;
      write_strobe_n        <= 1'b1;
    end else begin
      if (mss == `EBS_SEL_256K) begin
        port1_bit7_out <= lat_addr[`EBS_ADDR_A17]; // [R1]
      end else if (wait_control[`EBS_WCLK_EN_BIT]) begin
        port1_bit7_out <= wclk; // [R8]
      end else begin
        port1_bit7_out <= port1_bit7_gpio;
      end
      case (mss)
        `EBS_SEL_256K, `EBS_SEL_128K: port3_bit7_out <= lat_addr[`EBS_ADDR_A16]; // [R1]
        `EBS_SEL_64K: port3_bit7_out <= port3_bit7_gpio; // [R3]
        default: port3_bit7_out <= !(state == ebs_pkg::EBS_DATA && !lat_write
                                     && !prog_hit(mss, lat_addr)); // [R4]
      endcase
      program_read_strobe_n <= !(state == ebs_pkg::EBS_DATA && !lat_write
                                 && prog_hit(mss, lat_addr));
      write_strobe_n <= !(state == ebs_pkg::EBS_DATA && lat_write && wr_hit(mss, lat_addr));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_out <= 8'h0;
      port0_oe  <= 1'b0;
      port2_out <= 8'h0;
      port2_oe  <= 1'b0;
    end else begin
      port0_out <= lat_addr[7:0];
      port0_oe  <= state != ebs_pkg::EBS_IDLE;
      port2_out <= lat_addr[15:8];
      port2_oe  <= state != ebs_pkg::EBS_IDLE;
      if (state == ebs_pkg::EBS_DATA) begin
        if (page_mode) begin
          port2_out <= lat_wdata; // [R10]
          port2_oe  <= lat_write;
        end else begin
          port0_out <= lat_wdata;
          port0_oe  <= lat_write;
        end
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_addr_phase;
    state == ebs_pkg::EBS_ADDR;
  endsequence
  sequence s_data_read;
    state == ebs_pkg::EBS_DATA && !lat_write;
  endsequence

  a_a17_route: assert property (s_addr_phase ##0 mss == `EBS_SEL_256K // [R1]
    |=> port1_bit7_out == $past(lat_addr[`EBS_ADDR_A17]))
    else $error("A17 not on port1_bit7");
  a_wclk_route: assert property ((mss != `EBS_SEL_256K && wait_control[`EBS_WCLK_EN_BIT]) // [R8]
    |=> port1_bit7_out == $past(wclk))
    else $error("wait clock not routed");
  a_gpio_only: assert property (mss == `EBS_SEL_64K // [R3]
    |=> port3_bit7_out == $past(port3_bit7_gpio))
    else $error("port3_bit7 not a plain port");
  a_prog_strobe: assert property (s_data_read ##0 prog_hit(mss, lat_addr) // [R2]
    |=> !program_read_strobe_n)
    else $error("program read strobe missing");
  a_data_strobe: assert property (s_data_read ##0 mss == `EBS_SEL_COMPAT // [R4]
    ##0 lat_addr < ADDR_W'(`EBS_SPLIT_ADDR) |=> !port3_bit7_out && program_read_strobe_n)
    else $error("compat read strobes wrong");
  a_wr_legacy: assert property ((state == ebs_pkg::EBS_DATA && lat_write // [R5]
    && mss == `EBS_SEL_COMPAT && !wr_hit(mss, lat_addr)) |=> write_strobe_n)
    else $error("write strobe outside legacy region");
  a_wait_stretch: assert property (stalled |=> state == ebs_pkg::EBS_DATA ##0 !bus_done) // [R13]
    else $error("cycle not stretched");
  a_wait_off: assert property ((state == ebs_pkg::EBS_DATA // [R6]
    && !wait_control[`EBS_WAIT_EN_BIT]) |=> state == ebs_pkg::EBS_IDLE ##1 bus_done)
    else $error("wait input honoured while disabled");
  a_wclk_half: assert property (wait_control[`EBS_WCLK_EN_BIT] |=> wclk != $past(wclk)) // [R9]
    else $error("wait clock not toggling");
  a_page_addr: assert property (s_addr_phase ##0 page_mode // [R10]
    |=> port0_out == $past(lat_addr[7:0]) ##1 port0_out == $past(lat_addr[7:0], 2))
    else $error("page mode low address lost");
  a_cfg_hold: assert property (cfg_valid |=> $stable(mss) && $stable(page_mode)) // [R12]
    else $error("selection changed after capture");
endmodule
`default_nettype wire

// ===== ebs_mem_model.sv
// External memory model: answers reads on port 0 and stalls with the wait request
`timescale 1ns/10ps
`default_nettype none
module ebs_mem_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] stall_cycles,
  input  wire logic       bus_busy,
  input  wire logic [7:0] port0_out,
  input  wire logic       port0_oe,
  input  wire logic [7:0] port2_out,
  input  wire logic       port2_oe,
  output var  logic [7:0] port0_in,
  output var  logic [7:0] port2_in,
  output var  logic       wait_request_n
);
  logic [3:0] left;
  logic [7:0] idle_pat;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 4'h0;
      idle_pat <= 8'h00;
    end else begin
      left <= !bus_busy ? stall_cycles : left - 4'(left != 4'h0);
      idle_pat <= ~port0_in;
    end
  end
  // Memory byte is the high address byte scrambled; idle port 0 shows a pattern inverted each cycle
  always_comb begin
    port0_in = port0_oe ? port0_out : (bus_busy ? port2_out ^ 8'h5a : idle_pat);
    port2_in = port2_oe ? port2_out : 8'hff;
    wait_request_n = !(bus_busy && left != 4'h0);
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench of the external bus signal select block
`timescale 1ns/10ps
`default_nettype none
`include "ebs_consts.svh"
module tb_top;
  localparam logic [11:0] WCTL_A = 12'(`EBS_WAIT_CTRL_INDEX << 2);
  localparam logic [11:0] CFG_A  = 12'(`EBS_CFG_INDEX << 2);
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  memory_signal_select_strap;
  logic        page_mode_strap, bus_req, bus_write, bus_done, bus_busy, wait_request_n, e;
  logic [23:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, port0_in, port2_in, port0_out, port2_out;
  logic        port1_bit7_gpio, port3_bit7_gpio, port1_bit7_out, port3_bit7_out;
  logic        program_read_strobe_n, write_strobe_n, port0_oe, port2_oe;
  logic [3:0]  stall_cycles, pins;
  logic [18:0] pg;
  int          err_total, check_count, lat;
  ebs_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .memory_signal_select_strap, .page_mode_strap, .bus_req, .bus_addr, .bus_write,
    .bus_wdata, .bus_rdata, .bus_done, .bus_busy, .wait_request_n, .port1_bit7_gpio,
    .port3_bit7_gpio, .port0_in, .port2_in, .port1_bit7_out, .port3_bit7_out,
    .program_read_strobe_n, .write_strobe_n, .port0_out, .port0_oe, .port2_out, .port2_oe);
  ebs_mem_model mem (.pclk, .presetn, .stall_cycles, .bus_busy, .port0_out, .port0_oe,
    .port2_out, .port2_oe, .port0_in, .port2_in, .wait_request_n);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One edge passes so a following call never retakes psel in this step
    @(posedge pclk);
  endtask
  task automatic rst(input logic [1:0] s, input logic pg);
    presetn <= 1'b0;
    memory_signal_select_strap <= s;
    page_mode_strap <= pg;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // Pins are caught in the cycle after the last data phase cycle, where their registered copies show it, the one before bus_done is seen
  task automatic cyc(input logic [23:0] a, input logic w);
    bus_req <= 1'b1;
    bus_addr <= a;
    bus_write <= w;
    bus_wdata <= 8'hc3;
    lat = 0;
    do begin
      @(posedge pclk);
      lat++;
      if (lat == 1) bus_req <= 1'b0;
      if (bus_done !== 1'b1) begin
        pins = {port1_bit7_out, port3_bit7_out, program_read_strobe_n, write_strobe_n};
        pg = {port0_out, port0_oe, port2_out, port2_oe, bus_busy};
      end
    end while (bus_done !== 1'b1 && lat < 40);
  endtask
  task automatic t_regs;
    rst(2'h0, 1'b0);
    apb(1'b0, WCTL_A, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, WCTL_A, 32'hffff_ffff);
    apb(1'b0, WCTL_A, 32'h0);
    chk(q, 32'h3);
    apb(1'b0, 12'h3fc, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, CFG_A, 32'h7);
    apb(1'b0, CFG_A, 32'h0);
    chk(q, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_sel;
    logic [23:0] ad [4];
    logic [3:0]  x;
    ad = '{24'h0241c3, 24'h817e00, 24'h011234, 24'h005678};
    for (int s = 0; s < 4; s++) begin
      // Port latch high in code 10, so the plain pin value is told apart from address
      port3_bit7_gpio <= (s == 2);
      rst(2'(s), 1'b0);
      for (int i = 0; i < 4; i++) begin
        cyc(ad[i], i > 1);
        x[3] = s == 0 ? ad[i][17] : 1'b0;
        x[2] = s < 2 ? ad[i][16] : (s == 2 || i > 1 || ad[i] > 24'h7fffff);
        x[1] = i > 1 || (s == 3 && ad[i] < 24'h800000);
        x[0] = i < 2 || (s == 3 && ad[i][23:16] != 8'h01);
        chk(32'(pins), 32'(x));
        chk(32'(lat), 32'h5);
        if (i < 2) chk(32'(bus_rdata), 32'(ad[i][15:8] ^ 8'h5a));
      end
    end
    $display("test select done");
  endtask
  task automatic t_page;
    rst(2'h2, 1'b1);
    cyc(24'h009a3c, 1'b1);
    chk(32'(pg), 32'({8'h3c, 1'h1, 8'hc3, 1'h1, 1'h1}));
    $display("test page done");
  endtask
  task automatic t_wait;
    rst(2'h2, 1'b0);
    stall_cycles <= 4'h5;
    cyc(24'h001000, 1'b0);
    chk(32'(lat), 32'h5);
    apb(1'b1, WCTL_A, 32'h1);
    cyc(24'h001000, 1'b0);
    chk(32'(lat), 32'ha);
    stall_cycles <= 4'h0;
    $display("test wait done");
  endtask
  task automatic t_wclk;
    logic p;
    rst(2'h1, 1'b0);
    chk(32'(port1_bit7_out), 32'h0);
    apb(1'b1, WCTL_A, 32'h2);
    repeat (3) @(posedge pclk);
    p = port1_bit7_out;
    repeat (8) begin
      @(posedge pclk);
      chk(32'(port1_bit7_out), 32'(!p));
      p = port1_bit7_out;
    end
    apb(1'b1, WCTL_A, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(port1_bit7_out), 32'h0);
    $display("test wait clock done");
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #(50 * 5000);
    err_total++;
    finish_test;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, bus_req, bus_addr} = '0;
    {bus_write, bus_wdata, port1_bit7_gpio, port3_bit7_gpio, stall_cycles} = '0;
    err_total = 0;
    check_count = 0;
    t_regs;
    t_sel;
    t_page;
    t_wait;
    t_wclk;
    finish_test;
  end
endmodule
`default_nettype wire
